//--- usb_charger_detect_protect.sv
// top: port-type driven switch, fet, charger-detect and protection control
// assumes: analog detectors deliver asynchronous levels; software on ahb-lite
//
// The AHB-Lite slave port was chosen for this implementation.
module usb_charger_detect_protect
   import ucdp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire sense_t      sense_in,
   output switch_t          switch_out,
   output logic             charger_detect_n,
   output logic             input_disconnect
);

   // ***************************************************************
   // synchronised inputs and registers
   // ***************************************************************
   sense_t     s;
   logic [7:0] charger_control_q;
   logic [7:0] manual_switch_q;
   logic [1:0] device_control_q;
   logic [7:0] status_w;
   logic [3:0] event_set;
   logic       dplus_dead_q;

   // whole sense bundle crosses together; fields move slowly
   ucdp_sync #(.W($bits(sense_t))) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (sense_in),
      .sync_out (s)
   );

   // register slave; status and event inputs are built below
   ucdp_ahb_regs u_regs (
      .hclk              (hclk),
      .hresetn           (hresetn),
      .hsel              (hsel),
      .haddr             (haddr),
      .htrans            (htrans),
      .hwrite            (hwrite),
      .hready            (hready),
      .hwdata            (hwdata),
      .hrdata            (hrdata),
      .status_in         (status_w),
      .event_set         (event_set),
      .rid_code          (s.rid_code),
      .charger_control_q (charger_control_q),
      .manual_switch_q   (manual_switch_q),
      .device_control_q  (device_control_q)
   );

   // zero wait states, always okay
   // hsize is not decoded: only whole words are ever issued
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ***************************************************************
   // classification
   // ***************************************************************
   logic       man_en;
   logic       detach;
   logic       id_float;
   logic       bus_ok;
   port_kind_t port_w;
   logic       aca;
   logic       carkit;
   logic       auto_close;
   logic       chg_assert;
   logic       fet_auto;

   // charger adapters close the data path by themselves
   function automatic logic is_aca(input logic [4:0] c);
      return c == RID_ACA_A || c == RID_ACA_B || c == RID_ACA_C;
   endfunction

   // car-kit chargers keep the data path open
   function automatic logic is_carkit(input logic [4:0] c);
      return c == RID_CARKIT1 || c == RID_CARKIT2;
   endfunction

   // decode of the synchronised sense levels
   assign man_en   = device_control_q[MAN_SW_ENABLE_BIT];
   assign id_float = s.rid_code == RID_FLOAT;
   assign detach   = id_float && !s.bus_power_valid;
   assign bus_ok   = s.bus_power_valid && !s.over_voltage;
   assign port_w   = (bus_ok && s.bc_done) ? s.port_kind : PORT_NONE;
   assign aca      = is_aca(s.rid_code);
   assign carkit   = is_carkit(s.rid_code);

   // car kits and dcp stay open; sdp, cdp, aca auto close
   assign auto_close = bus_ok && !carkit && !man_en &&
                       (aca || (id_float && (port_w == PORT_SDP ||
                                             port_w == PORT_CDP)));
   assign chg_assert = bus_ok && (carkit || aca ||
                       (id_float && (port_w == PORT_CDP ||
                                     port_w == PORT_DCP)));

   // limitation: ovp also hides the port kind, as bus_ok drops
   // with a floating id, fet follows bc completion so fet and sdp/cdp data switches move together; on dcp only the fet closes
   assign fet_auto = bus_ok && (s.bc_done || !id_float) &&
                     (!man_en || manual_switch_q[1:0] == MAN_FET_CLOSED);

   // ***************************************************************
   // protection state
   // ***************************************************************
   // one state flag for each kind of shutdown
   logic ovp_q;
   logic ocp_q;
   logic ovp_next;
   logic ocp_next;

   assign ovp_next = s.over_voltage && !detach;
   assign ocp_next = s.over_current && !detach && fet_auto;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovp_q <= 1'b0;
      end else begin
         ovp_q <= ovp_next;
      end
   end

   // ocp latches open the fet until current falls or detach
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ocp_q <= 1'b0;
      end else if (ocp_q) begin
         ocp_q <= s.over_current && !detach;
      end else begin
         ocp_q <= ocp_next;
      end
   end

   // ***************************************************************
   // events: change of protection state, id change, bus valid change
   // ***************************************************************
   // one-cycle history; reset values match the idle sense
   logic       ovp_d1_q;
   logic       ocp_d1_q;
   logic       bus_d1_q;
   logic [4:0] rid_d1_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovp_d1_q <= 1'b0;
         ocp_d1_q <= 1'b0;
         bus_d1_q <= 1'b0;
         rid_d1_q <= RID_FLOAT;
      end else begin
         ovp_d1_q <= ovp_q;
         ocp_d1_q <= ocp_q;
         bus_d1_q <= s.bus_power_valid;
         rid_d1_q <= s.rid_code;
      end
   end

   assign event_set[EV_OVP_BIT]  = ovp_q ^ ovp_d1_q;
   assign event_set[EV_OCP_BIT]  = ocp_q ^ ocp_d1_q;
   assign event_set[EV_RID_BIT]  = s.audio_attached &&
                                   !device_control_q[ID_DETECT_DISABLE_BIT] &&
                                   (s.rid_code != rid_d1_q);
   assign event_set[EV_VBUS_BIT] = s.bus_power_valid ^ bus_d1_q;

   // port kind in low bits, protection flags above
   // status reads live levels; only events latch
   assign status_w = {2'h0, s.bus_power_valid, dplus_dead_q, ocp_q, ovp_q,
                      port_w};

   // ***************************************************************
   // dead battery d+ source
   // ***************************************************************
   // supplies win over a new port, so a returning supply stops it

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dplus_dead_q <= 1'b0;
      end else if (detach || s.io_supply_valid || s.battery_valid) begin
         dplus_dead_q <= 1'b0;
      end else if (port_w != PORT_NONE) begin
         dplus_dead_q <= 1'b1;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   // registered pins keep decode glitches off the switches
   logic host_close;
   logic dplus_man;

   // factory path: plain id resistance together with a valid standard port closes host switches
   assign host_close = !detach && ((auto_close) ||
                       (!man_en && !carkit && !id_float && !aca && bus_ok &&
                        s.bc_done && port_w == PORT_SDP) ||
                       (man_en && manual_switch_q[2]));
   assign dplus_man  = charger_control_q[DPLUS_SOURCE_BIT] && bus_ok;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         switch_out       <= '0;
         charger_detect_n <= 1'b1;
         input_disconnect <= 1'b0;
      end else begin
         switch_out.host_dplus_port  <= host_close;
         switch_out.host_dminus_port <= host_close;
         switch_out.bus_fet_on       <= fet_auto && !ocp_q && !detach;
         switch_out.dplus_source     <= (dplus_dead_q || dplus_man) && !detach;
         switch_out.mic_to_vbus      <= man_en && manual_switch_q[3] && !detach;
         switch_out.mic_to_dplus     <= man_en && manual_switch_q[4] && !detach;
         charger_detect_n            <= !chg_assert;
         input_disconnect            <= ovp_q;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   a_detach_opens: assert property (@(posedge hclk) disable iff (!hresetn)
      detach |=> !switch_out.host_dplus_port && !switch_out.bus_fet_on)
      else $error("detach left a switch closed");

   a_no_vbus_detect: assert property (@(posedge hclk) disable iff (!hresetn)
      !s.bus_power_valid |=> charger_detect_n)
      else $error("charger detect without bus power");

   a_ovp_event: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(ovp_q) |-> event_set[EV_OVP_BIT] ##1 input_disconnect)
      else $error("over-voltage entry not reported");

   a_ocp_fet: assert property (@(posedge hclk) disable iff (!hresetn)
      ocp_q |=> !switch_out.bus_fet_on)
      else $error("fet on during over-current");

   a_ocp_exit: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(ocp_q) |-> event_set[EV_OCP_BIT])
      else $error("over-current exit not reported");

   a_manual_fet: assert property (@(posedge hclk) disable iff (!hresetn)
      man_en && manual_switch_q[1:0] != MAN_FET_CLOSED |=> !switch_out.bus_fet_on)
      else $error("fet closed against manual setting");

   a_dead_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      s.io_supply_valid |=> !dplus_dead_q)
      else $error("dead battery source not withdrawn");

   a_carkit_open: assert property (@(posedge hclk) disable iff (!hresetn)
      carkit && !man_en && bus_ok |=> !switch_out.host_dplus_port && !charger_detect_n)
      else $error("car kit handling wrong");

   // ***************************************************************
   // checks on the port table
   // ***************************************************************
   a_dcp_open: assert property (@(posedge hclk) disable iff (!hresetn)
      id_float && port_w == PORT_DCP && !man_en |=>
         !switch_out.host_dplus_port && !charger_detect_n)
      else $error("dedicated port left switches closed");

   a_cdp_close: assert property (@(posedge hclk) disable iff (!hresetn)
      id_float && port_w == PORT_CDP && !man_en |=>
         switch_out.host_dplus_port && switch_out.host_dminus_port && !charger_detect_n)
      else $error("charging port handling wrong");

   a_sdp_close: assert property (@(posedge hclk) disable iff (!hresetn)
      id_float && port_w == PORT_SDP && !man_en |=>
         switch_out.host_dplus_port && charger_detect_n)
      else $error("standard port handling wrong");

   a_aca_close: assert property (@(posedge hclk) disable iff (!hresetn)
      aca && bus_ok && !man_en |=> switch_out.host_dplus_port && !charger_detect_n)
      else $error("adapter handling wrong");

   a_fet_auto: assert property (@(posedge hclk) disable iff (!hresetn)
      bus_ok && s.bc_done && !man_en && !ocp_q |=> switch_out.bus_fet_on)
      else $error("fet not closed on valid bus");

   // ***************************************************************
   // checks on the d+ source, shutdown exit and mic routing
   // ***************************************************************
   a_dead_source: assert property (@(posedge hclk) disable iff (!hresetn)
      dplus_dead_q && !detach |=> switch_out.dplus_source)
      else $error("dead battery source missing");

   a_dead_detach: assert property (@(posedge hclk) disable iff (!hresetn)
      detach |=> !switch_out.dplus_source)
      else $error("d+ source left on at detach");

   a_dplus_no_bus: assert property (@(posedge hclk) disable iff (!hresetn)
      !bus_ok && !dplus_dead_q |=> !switch_out.dplus_source)
      else $error("manual d+ source without bus power");

   a_ovp_exit: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(ovp_q) |-> event_set[EV_OVP_BIT] ##1 !input_disconnect)
      else $error("over-voltage exit not reported");

   a_mic_detach: assert property (@(posedge hclk) disable iff (!hresetn)
      detach |=> !switch_out.mic_to_vbus && !switch_out.mic_to_dplus)
      else $error("mic path left closed at detach");

endmodule

//--- ucdp_pkg.sv
// package: register map, field positions, resets, structs and enums for the port controller
// assumes: a single 20 MHz clock domain; analog sense results arrive as digital levels
package ucdp_pkg;

   // ***************************************************************
   // register map (byte addresses, one word each)
   // ***************************************************************
   localparam logic [7:0] ADDR_CHARGER_CONTROL = 8'h14;
   localparam logic [7:0] ADDR_MANUAL_SWITCH   = 8'h18;
   localparam logic [7:0] ADDR_DEVICE_CONTROL  = 8'h1c;
   localparam logic [7:0] ADDR_STATUS          = 8'h20;
   localparam logic [7:0] ADDR_EVENTS          = 8'h24;
   localparam logic [7:0] ADDR_RESISTOR_CODE   = 8'h28;

   // field positions
   localparam int DPLUS_SOURCE_BIT   = 2;
   localparam int MAN_SW_ENABLE_BIT  = 0;
   localparam int ID_DETECT_DISABLE_BIT         = 1;
   localparam int EV_OVP_BIT         = 0;
   localparam int EV_OCP_BIT         = 1;
   localparam int EV_RID_BIT         = 2;
   localparam int EV_VBUS_BIT        = 3;

   // reset values
   localparam logic [7:0] CHARGER_CONTROL_RST = 8'h00;
   localparam logic [7:0] MANUAL_SWITCH_RST   = 8'h00;
   localparam logic [1:0] DEVICE_CONTROL_RST  = 2'h0;

   // switch codes and resistor codes
   localparam logic [1:0] MAN_FET_CLOSED  = 2'h3;
   localparam logic [4:0] RID_FLOAT       = 5'h00;
   localparam logic [4:0] RID_CARKIT1     = 5'h07;
   localparam logic [4:0] RID_CARKIT2     = 5'h03;
   localparam logic [4:0] RID_ACA_A       = 5'h0a;
   localparam logic [4:0] RID_ACA_B       = 5'h0d;
   localparam logic [4:0] RID_ACA_C       = 5'h11;

   // bc1.2 result from the analog detector
   typedef enum logic [1:0] {PORT_NONE, PORT_SDP, PORT_CDP, PORT_DCP} port_kind_t;

   // analog sense inputs, all levels
   typedef struct packed {
      logic       bus_power_valid;
      logic       over_voltage;
      logic       over_current;
      logic       battery_valid;
      logic       io_supply_valid;
      logic       bc_done;
      port_kind_t port_kind;
      logic [4:0] rid_code;
      logic       audio_attached;
   } sense_t;

   // switch and pin controls towards the analog domain
   typedef struct packed {
      logic host_dplus_port;
      logic host_dminus_port;
      logic bus_fet_on;
      logic dplus_source;
      logic mic_to_vbus;
      logic mic_to_dplus;
   } switch_t;

endpackage

//--- ucdp_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
// assumes: inputs change slowly relative to hclk
module ucdp_sync
   import ucdp_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // first stage only feeds the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

//--- ucdp_ahb_regs.sv
// ahb-lite slave for the control, status and event registers
// assumes: single word transfers, zero wait states, one master
module ucdp_ahb_regs
   import ucdp_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   input  wire logic [7:0]  status_in,
   input  wire logic [3:0]  event_set,
   input  wire logic [4:0]  rid_code,
   output logic      [7:0]  charger_control_q,
   output logic      [7:0]  manual_switch_q,
   output logic      [1:0]  device_control_q
);

   logic       wr_q;
   logic [7:0] wa_q;
   logic [3:0] events_q;
   logic       acc;

   assign acc = hsel && hready && htrans[1];

   // address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         wa_q <= 8'h00;
      end else begin
         wr_q <= acc && hwrite;
         wa_q <= haddr;
      end
   end

   // writable registers, data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         charger_control_q <= CHARGER_CONTROL_RST;
         manual_switch_q   <= MANUAL_SWITCH_RST;
         device_control_q  <= DEVICE_CONTROL_RST;
      end else if (wr_q) begin
         case (wa_q)
            ADDR_CHARGER_CONTROL: charger_control_q <= hwdata[7:0];
            ADDR_MANUAL_SWITCH:   manual_switch_q   <= hwdata[7:0];
            ADDR_DEVICE_CONTROL:  device_control_q  <= hwdata[1:0];
            default: ;
         endcase
      end
   end

   // event bits: write one to clear, a new event wins over the clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         events_q <= 4'h0;
      end else if (wr_q && wa_q == ADDR_EVENTS) begin
         events_q <= (events_q & ~hwdata[3:0]) | event_set;
      end else begin
         events_q <= events_q | event_set;
      end
   end

   // read data registered at the address phase; unmapped reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (acc && !hwrite) begin
         case (haddr)
            ADDR_CHARGER_CONTROL: hrdata <= {24'h0, charger_control_q};
            ADDR_MANUAL_SWITCH:   hrdata <= {24'h0, manual_switch_q};
            ADDR_DEVICE_CONTROL:  hrdata <= {30'h0, device_control_q};
            ADDR_STATUS:          hrdata <= {24'h0, status_in};
            ADDR_EVENTS:          hrdata <= {28'h0, events_q};
            ADDR_RESISTOR_CODE:   hrdata <= {27'h0, rid_code};
            default:              hrdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

//--- accessory_model.sv
// behavioural accessory, charger and supplies that drive the sense inputs
// assumes: bench calls its tasks from one process, just after hclk edges
module accessory_model
   import ucdp_pkg::*;
#(
   parameter int HOLD = 8
) (
   input  wire logic    hclk,
   input  wire switch_t switch_out,
   output sense_t       sense_in
);
   timeunit 1ns;
   timeprecision 1ps;

   sense_t s_q;
   int     on_cnt;

   // cycles since the fet closed; heavy draw waits for it
   always @(posedge hclk) on_cnt <= switch_out.bus_fet_on ? on_cnt + 1 : 0;

   initial begin
      s_q                 = '0;
      s_q.battery_valid   = 1'b1;
      s_q.io_supply_valid = 1'b1;
   end
   assign sense_in = s_q;

   // *********************
   // attach and detach
   // *********************
   task automatic plug(input logic b, input port_kind_t k, input logic [4:0] r,
                       input logic bc, input logic a);
      @(posedge hclk);
      s_q.bus_power_valid <= b;
      s_q.port_kind       <= k;
      s_q.rid_code        <= r;
      s_q.bc_done         <= bc;
      s_q.audio_attached  <= a;
   endtask

   task automatic supplies(input logic b, input logic io);
      @(posedge hclk);
      s_q.battery_valid   <= b;
      s_q.io_supply_valid <= io;
   endtask

   // overload only after the output stood valid a while
   task automatic faults(input logic ov, input logic oc);
      while (oc && on_cnt < HOLD) @(posedge hclk);
      @(posedge hclk);
      s_q.over_voltage <= ov;
      s_q.over_current <= oc;
   endtask
endmodule

//--- usb_charger_detect_protect_bench.sv
// self-checking bench: ahb-lite master, accessory model, result queue
// assumes: zero-wait slave, 3 cycle sense to output latency
module usb_charger_detect_protect_bench
   import ucdp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {logic [31:0] exp; logic [31:0] mask;} note_t;

   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_ph = 0, chk_ph = 0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, got;
   logic        hreadyout, hresp, charger_detect_n, input_disconnect;
   sense_t      sense_in;
   switch_t     switch_out;
   logic [7:0]  outs;
   note_t       q[$], n;
   int          mismatches = 0, compares = 0, seed = 38, i;
   logic [31:0] rv;
   // last entry: a plain id resistance on a standard port (factory cable)
   port_kind_t  kt[8] = '{PORT_DCP, PORT_CDP, PORT_SDP, PORT_DCP, PORT_DCP, PORT_SDP, PORT_SDP,
                          PORT_SDP};
   logic [4:0]  rt[8] = '{RID_FLOAT, RID_FLOAT, RID_FLOAT, RID_CARKIT1, RID_CARKIT2,
                          RID_ACA_A, RID_ACA_B, 5'h14};
   logic [7:0]  et[8] = '{8'h20, 8'he0, 8'he2, 8'h20, 8'h20, 8'he0, 8'he0, 8'he2};

   always #25 hclk = ~hclk;
   assign outs = {switch_out, charger_detect_n, input_disconnect};

   usb_charger_detect_protect u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sense_in(sense_in), .switch_out(switch_out), .charger_detect_n(charger_detect_n),
      .input_disconnect(input_disconnect));

   accessory_model u_acc (.hclk(hclk), .switch_out(switch_out), .sense_in(sense_in));

   // *********************
   // result monitor
   // *********************
   // notes are taken in order, one per read data phase or output sample
   always @(posedge hclk) begin
      if (rd_ph || chk_ph) begin
         n = q.pop_front();
         got = rd_ph ? hrdata : {24'h0, outs};
         compares++;
         if ((got & n.mask) !== (n.exp & n.mask) || (rd_ph && hresp !== 1'b0)) begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, n.exp & n.mask, got & n.mask);
         end
      end
   end

   // *********************
   // bus and check tasks
   // *********************
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      rd_ph  <= ~w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd_ph  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      q.push_back('{e, m});
      xfer(a, 1'b0, 32'h0);
   endtask

   // settle covers the three cycle sense latency
   task automatic chk(input logic [7:0] e, input logic [7:0] m);
      repeat (5) @(posedge hclk);
      q.push_back('{{24'h0, e}, {24'h0, m}});
      chk_ph <= 1'b1;
      @(posedge hclk);
      chk_ph <= 1'b0;
   endtask

   task automatic done(input string s);
      $display("test %s done", s);
   endtask

   task automatic results;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // watchdog well beyond the run of roughly 400 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      results();
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped place, random read-back
      rd(ADDR_CHARGER_CONTROL, {24'h0, CHARGER_CONTROL_RST}, 32'hffffffff);
      rd(ADDR_MANUAL_SWITCH, {24'h0, MANUAL_SWITCH_RST}, 32'hffffffff);
      rd(ADDR_DEVICE_CONTROL, {30'h0, DEVICE_CONTROL_RST}, 32'hffffffff);
      rd(8'h3c, 32'h0, 32'hffffffff);
      chk(8'h02, 8'hff);
      rv = $random(seed) & 32'hfb;  // bit 2 kept clear: no d+ source yet
      wr(ADDR_CHARGER_CONTROL, rv);
      rd(ADDR_CHARGER_CONTROL, rv, 32'hffffffff);
      wr(ADDR_CHARGER_CONTROL, 32'h0);
      done("reset");
      // port table: switches, fet, detect, code and kind reporting
      for (i = 0; i < 8; i++) begin
         u_acc.plug(1'b1, kt[i], rt[i], 1'b1, 1'b0);
         chk(et[i], 8'he2);
         rd(ADDR_RESISTOR_CODE, {27'h0, rt[i]}, 32'h1f);
         // bus valid bit (bit 5) is checked along with the port kind
         rd(ADDR_STATUS, 32'h20 | kt[i], 32'h23);
         u_acc.plug(1'b0, PORT_NONE, RID_FLOAT, 1'b0, 1'b0);
         chk(8'h02, 8'hfe);
      end
      u_acc.plug(1'b0, PORT_NONE, RID_CARKIT1, 1'b0, 1'b0);
      chk(8'h02, 8'h22);
      rd(ADDR_RESISTOR_CODE, {27'h0, RID_CARKIT1}, 32'h1f);
      rd(ADDR_STATUS, 32'h0, 32'h23);
      done("ports");
      // manual switching, mic routing, detach in manual mode
      wr(ADDR_DEVICE_CONTROL, 32'h1);
      u_acc.plug(1'b1, PORT_DCP, RID_FLOAT, 1'b1, 1'b0);
      chk(8'h00, 8'h20);
      wr(ADDR_MANUAL_SWITCH, 32'h07);
      chk(8'he0, 8'he0);
      wr(ADDR_MANUAL_SWITCH, 32'h0b);
      chk(8'h08, 8'h0c);
      wr(ADDR_MANUAL_SWITCH, 32'h13);
      chk(8'h04, 8'h0c);
      u_acc.plug(1'b0, PORT_NONE, RID_FLOAT, 1'b0, 1'b0);
      chk(8'h02, 8'hfe);
      wr(ADDR_DEVICE_CONTROL, 32'h0);
      wr(ADDR_MANUAL_SWITCH, 32'h0);
      done("manual");
      // manual and dead-battery d+ source
      u_acc.plug(1'b1, PORT_SDP, RID_FLOAT, 1'b1, 1'b0);
      wr(ADDR_CHARGER_CONTROL, 32'h1 << DPLUS_SOURCE_BIT);
      chk(8'h10, 8'h10);
      wr(ADDR_CHARGER_CONTROL, 32'h0);
      chk(8'h00, 8'h10);
      u_acc.supplies(1'b0, 1'b0);
      chk(8'h10, 8'h10);
      rd(ADDR_STATUS, 32'h10, 32'h10);
      u_acc.supplies(1'b0, 1'b1);
      chk(8'h00, 8'h10);
      u_acc.supplies(1'b1, 1'b1);
      done("dplus");
      // over-voltage entry and exit
      wr(ADDR_EVENTS, 32'hf);
      u_acc.faults(1'b1, 1'b0);
      chk(8'h01, 8'h01);
      rd(ADDR_STATUS, 32'h04, 32'h04);
      rd(ADDR_EVENTS, 32'h01, 32'h01);
      wr(ADDR_EVENTS, 32'h1);
      u_acc.faults(1'b0, 1'b0);
      chk(8'h00, 8'h01);
      rd(ADDR_STATUS, 32'h00, 32'h04);
      rd(ADDR_EVENTS, 32'h01, 32'h01);
      // over-current entry and exit
      wr(ADDR_EVENTS, 32'hf);
      u_acc.faults(1'b0, 1'b1);
      chk(8'h00, 8'h20);
      rd(ADDR_STATUS, 32'h08, 32'h08);
      rd(ADDR_EVENTS, 32'h02, 32'h02);
      wr(ADDR_EVENTS, 32'h2);
      u_acc.faults(1'b0, 1'b0);
      chk(8'h20, 8'h20);
      rd(ADDR_STATUS, 32'h00, 32'h08);
      rd(ADDR_EVENTS, 32'h02, 32'h02);
      done("protect");
      // audio resistor change with id detection on, then off
      u_acc.plug(1'b0, PORT_NONE, 5'h0f, 1'b0, 1'b1);
      chk(8'h02, 8'h3f);
      rd(ADDR_EVENTS, 32'h0c, 32'h0c);
      wr(ADDR_EVENTS, 32'hf);
      u_acc.plug(1'b0, PORT_NONE, 5'h0e, 1'b0, 1'b1);
      chk(8'h02, 8'h3f);
      rd(ADDR_EVENTS, 32'h04, 32'h04);
      wr(ADDR_DEVICE_CONTROL, 32'h1 << ID_DETECT_DISABLE_BIT);
      wr(ADDR_EVENTS, 32'hf);
      u_acc.plug(1'b0, PORT_NONE, 5'h0f, 1'b0, 1'b1);
      chk(8'h02, 8'h3f);
      rd(ADDR_EVENTS, 32'h00, 32'h04);
      done("audio");
      results();
   end
endmodule
